/* File: core/nbe_detect.sv */
`timescale 1ns/100ps
module nbe_detect (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cor_err_i,
    input wire logic unc_err_i,
    input wire logic fetch_i,
    input wire logic [1:0] clk_src_i,
    input wire logic [7:0] clk_mhz_i,
    input wire logic lpm_wake_i,
    nbe_evt_if.src evt
);

    // ------------------------------------------------------------
    // Clock condition under which spurious detections appear
    // ------------------------------------------------------------
    logic fast_clock;
    always_comb
    begin
        if (clk_src_i == nbe_pkg::SRC_TUNABLE)
        begin
            fast_clock = (clk_mhz_i == nbe_pkg::TUNABLE_OSC_BAD_MHZ);
        end
        else if (clk_src_i == nbe_pkg::SRC_EXT_INPUT || clk_src_i == nbe_pkg::SRC_CRYSTAL)
        begin
            fast_clock = (clk_mhz_i > nbe_pkg::FALSE_DET_LIMIT_MHZ);
        end
        else
        begin
            fast_clock = 1'b0;
        end
    end

    // A pseudo-random toggle models the intermittent nature of the defect.
    logic [7:0] lfsr;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lfsr <= 8'h01;
        end
        else
        begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end

    // ------------------------------------------------------------
    // Event qualification, one cycle
    // ------------------------------------------------------------
    // After wake-up the first access may also report an error; modelled by
    // passing the wake strobe on as a spurious error of the lfsr's choosing.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            evt.cor_evt <= 1'b0;
            evt.unc_evt <= 1'b0;
            evt.false_unc_evt <= 1'b0;
        end
        else
        begin
            evt.cor_evt <= cor_err_i | (lpm_wake_i & lfsr[0]);
            evt.unc_evt <= unc_err_i | (lpm_wake_i & ~lfsr[0]);
            evt.false_unc_evt <= fetch_i & fast_clock & lfsr[7] & lfsr[2] & lfsr[1];
        end
    end

endmodule

/* File: core/nbe_evt_if.sv */
`timescale 1ns/100ps
// Qualified error events passed from the detection front end to the reporter.
interface nbe_evt_if;
    logic cor_evt;
    logic unc_evt;
    logic false_unc_evt;
    modport src (output cor_evt, output unc_evt, output false_unc_evt);
    modport dst (input cor_evt, input unc_evt, input false_unc_evt);
endinterface

/* File: core/nbe_pkg.sv */
package nbe_pkg;

    // ------------------------------------------------------------
    // Register map (word aligned, classic Wishbone, 32-bit data)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_RESET_VEC = 8'h08;
    localparam logic [7:0] ADDR_NMI_VEC = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_RST_EN = 0;
    localparam int CTL_UNC_IE = 1;
    localparam int CTL_COR_IE = 2;
    localparam int FLG_COR = 0;
    localparam int FLG_UNC = 1;
    localparam int ST_LPM_WAKE = 0;
    localparam int ST_RESET_REQ = 1;

    // ------------------------------------------------------------
    // Reset values and vector codes
    // ------------------------------------------------------------
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] RST_CODE_UNC = 8'h1C;
    localparam logic [7:0] NMI_CODE_UNC = 8'h02;
    localparam logic [7:0] NMI_CODE_COR = 8'h04;

    // ------------------------------------------------------------
    // Clock thresholds for the false-detection defect, in MHz
    // ------------------------------------------------------------
    localparam logic [7:0] FALSE_DET_LIMIT_MHZ = 8'h0C;
    localparam logic [7:0] TUNABLE_OSC_BAD_MHZ = 8'h10;
    localparam logic [1:0] SRC_TUNABLE = 2'h0;
    localparam logic [1:0] SRC_EXT_INPUT = 2'h1;
    localparam logic [1:0] SRC_CRYSTAL = 2'h2;

    // Cycles for which a power_up_clear_reset request pulse stands.
    localparam int RESET_PULSE_NS = 20;
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [3:0] RESET_PULSE_CYC = 4'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

/* File: core/nbe_top.sv */
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
// What this block does
// - An uncorrectable error found by detection sets the uncorrectable flag.
// - With reset enable set, uncorrectable error requests reset and records reset code.
// - Uncorrectable interrupt enable set would raise NMI with code (see defect).
// - Correctable interrupt enable set: correctable error raises NMI and records code.
// - Defect: uncorrectable flag with reset off raises no NMI; NMI vector stays 0.
// - Defect: fast main clock while fetching may give a false uncorrectable reset.
// - Defect: that false reset leaves reset vector 0 and the flag clear.
// - Defect: after low-power wake-up, spurious errors may be reported.
module nbe_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic cor_err_i,
    input wire logic unc_err_i,
    input wire logic fetch_i,
    input wire logic [1:0] clk_src_i,
    input wire logic [7:0] clk_mhz_i,
    input wire logic lpm_wake_i,
    input wire logic por_i,
    output logic nmi_o,
    output logic puc_o
);

    // ------------------------------------------------------------
    // Synchronisers for pins from outside the clock domain
    // ------------------------------------------------------------
    logic [1:0] cor_sync;
    logic [1:0] unc_sync;
    logic [1:0] wake_sync;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cor_sync <= 2'h0;
            unc_sync <= 2'h0;
            wake_sync <= 2'h0;
        end
        else
        begin
            cor_sync <= {cor_sync[0], cor_err_i};
            unc_sync <= {unc_sync[0], unc_err_i};
            wake_sync <= {wake_sync[0], lpm_wake_i};
        end
    end

    // Wake and both error pins are levels; only a rising edge counts as an event.
    // An error level that stands for several cycles is one detection, not many.
    logic wake_q;
    logic cor_q;
    logic unc_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wake_q <= 1'b0;
            cor_q <= 1'b0;
            unc_q <= 1'b0;
        end
        else
        begin
            wake_q <= wake_sync[1];
            cor_q <= cor_sync[1];
            unc_q <= unc_sync[1];
        end
    end

    nbe_evt_if evt ();

    nbe_detect u_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cor_err_i(cor_sync[1] & ~cor_q),
        .unc_err_i(unc_sync[1] & ~unc_q),
        .fetch_i(fetch_i),
        .clk_src_i(clk_src_i),
        .clk_mhz_i(clk_mhz_i),
        .lpm_wake_i(wake_sync[1] & ~wake_q),
        .evt(evt.src)
    );

    // ------------------------------------------------------------
    // Wishbone decode
    // ------------------------------------------------------------
    logic access;
    logic wr;
    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = access & wb_we_i & wb_sel_i[0];

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] target);
        hit = (adr == target);
    endfunction

    // Single-cycle answer: ack rises one edge after the request and drops after.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= access;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [2:0] control;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control <= nbe_pkg::CONTROL_RESET;
        end
        else if (wr && hit(wb_adr_i, nbe_pkg::ADDR_CONTROL))
        begin
            control <= wb_dat_i[2:0];
        end
    end

    logic rst_en;
    logic unc_ie;
    logic cor_ie;
    assign rst_en = control[nbe_pkg::CTL_RST_EN];
    assign unc_ie = control[nbe_pkg::CTL_UNC_IE];
    assign cor_ie = control[nbe_pkg::CTL_COR_IE];

    // ------------------------------------------------------------
    // Error flags
    // ------------------------------------------------------------
    // Flags survive a power_up_clear_reset on purpose: software must find the
    // uncorrectable flag after the reset it caused. Only por_i or software clears.
    logic flag_cor;
    logic flag_unc;
    logic clr_flags;
    assign clr_flags = wr && hit(wb_adr_i, nbe_pkg::ADDR_FLAGS);
    always_ff @(posedge clk_i)
    begin
        if (por_i)
        begin
            flag_cor <= 1'b0;
            flag_unc <= 1'b0;
        end
        else
        begin
            // Write one to clear; a new event in the same cycle wins.
            if (evt.cor_evt)
            begin
                flag_cor <= 1'b1;
            end
            else if (clr_flags && wb_dat_i[nbe_pkg::FLG_COR])
            begin
                flag_cor <= 1'b0;
            end
            if (evt.unc_evt)
            begin
                flag_unc <= 1'b1;
            end
            else if (clr_flags && wb_dat_i[nbe_pkg::FLG_UNC])
            begin
                flag_unc <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset request and reset vector
    // ------------------------------------------------------------
    // A false detection resets without a code or a flag, which is why software
    // may treat a zero reset vector as spurious.
    logic unc_reset;
    logic false_reset;
    assign unc_reset = evt.unc_evt & rst_en;
    assign false_reset = evt.false_unc_evt & rst_en & ~evt.unc_evt;

    logic [7:0] reset_vec;
    always_ff @(posedge clk_i)
    begin
        if (por_i)
        begin
            reset_vec <= nbe_pkg::VEC_NONE;
        end
        else if (unc_reset)
        begin
            reset_vec <= nbe_pkg::RST_CODE_UNC;
        end
        else if (false_reset)
        begin
            reset_vec <= nbe_pkg::VEC_NONE;
        end
        else if (access && !wb_we_i && hit(wb_adr_i, nbe_pkg::ADDR_RESET_VEC))
        begin
            reset_vec <= nbe_pkg::VEC_NONE; // Reading the vector consumes it.
        end
    end

    // A request while a pulse runs is absorbed by it, so every pulse has the
    // same length and is followed by at least one quiet cycle.
    logic [3:0] puc_cnt;
    logic puc_start;
    assign puc_start = (unc_reset || false_reset) && (puc_cnt == 4'h0);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            puc_cnt <= 4'h0;
        end
        else if (puc_start)
        begin
            puc_cnt <= nbe_pkg::RESET_PULSE_CYC;
        end
        else if (puc_cnt != 4'h0)
        begin
            puc_cnt <= puc_cnt - 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            puc_o <= 1'b0;
        end
        else
        begin
            puc_o <= puc_start | (puc_cnt > 4'h1);
        end
    end

    // ------------------------------------------------------------
    // NMI and NMI vector
    // ------------------------------------------------------------
    // The uncorrectable interrupt path only fires alongside the reset; with
    // reset disabled it is silently lost, matching the known silicon.
    logic unc_nmi;
    logic cor_nmi;
    assign unc_nmi = evt.unc_evt & unc_ie & rst_en;
    assign cor_nmi = evt.cor_evt & cor_ie;

    logic [7:0] nmi_vec;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nmi_vec <= nbe_pkg::VEC_NONE;
        end
        else if (unc_nmi)
        begin
            nmi_vec <= nbe_pkg::NMI_CODE_UNC;
        end
        else if (cor_nmi)
        begin
            nmi_vec <= nbe_pkg::NMI_CODE_COR;
        end
        else if (access && !wb_we_i && hit(wb_adr_i, nbe_pkg::ADDR_NMI_VEC))
        begin
            nmi_vec <= nbe_pkg::VEC_NONE;
        end
    end

    // NMI stays high while a code is pending.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nmi_o <= 1'b0;
        end
        else
        begin
            nmi_o <= unc_nmi | cor_nmi | ((nmi_vec != nbe_pkg::VEC_NONE) &&
                     !(access && !wb_we_i && hit(wb_adr_i, nbe_pkg::ADDR_NMI_VEC)));
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit(wb_adr_i, nbe_pkg::ADDR_CONTROL))
        begin
            next_rdata[2:0] = control;
        end
        else if (hit(wb_adr_i, nbe_pkg::ADDR_FLAGS))
        begin
            next_rdata[nbe_pkg::FLG_COR] = flag_cor;
            next_rdata[nbe_pkg::FLG_UNC] = flag_unc;
        end
        else if (hit(wb_adr_i, nbe_pkg::ADDR_RESET_VEC))
        begin
            next_rdata[7:0] = reset_vec;
        end
        else if (hit(wb_adr_i, nbe_pkg::ADDR_NMI_VEC))
        begin
            next_rdata[7:0] = nmi_vec;
        end
        else if (hit(wb_adr_i, nbe_pkg::ADDR_STATUS))
        begin
            next_rdata[nbe_pkg::ST_LPM_WAKE] = wake_q;
            next_rdata[nbe_pkg::ST_RESET_REQ] = (puc_cnt != 4'h0);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (access && !wb_we_i)
        begin
            wb_dat_o <= next_rdata;
        end
    end

endmodule

/* File: testbench/nbe_nvm_model.sv */
`timescale 1ns/100ps
// ------------------------------------------
// Memory array and system reset model
// ------------------------------------------
module nbe_nvm_model #(
    parameter int HOLD = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic inj_cor_i,
    input wire logic inj_unc_i,
    input wire logic puc_i,
    output logic cor_err_o,
    output logic unc_err_o,
    output int puc_count_o
);
    int hold;
    logic puc_d;
    // An error level stands long enough for a two-stage synchroniser, then drops.
    always_ff @(posedge clk_i)
        if (rst_i || inj_cor_i || inj_unc_i)
        begin
            cor_err_o <= inj_cor_i && !rst_i;
            unc_err_o <= inj_unc_i && !rst_i;
            hold <= HOLD;
        end
        else if (hold > 0)
            hold <= hold - 1;
        else
        begin
            cor_err_o <= 1'b0;
            unc_err_o <= 1'b0;
        end
    // The system reset logic counts requests; the count survives every reset.
    always_ff @(posedge clk_i)
    begin
        puc_d <= puc_i;
        if (puc_i && !puc_d)
            puc_count_o <= puc_count_o + 1;
    end
endmodule

/* File: testbench/nbe_properties.sv */
`timescale 1ns/100ps
// ------------------------------------------
// Port checks of the error reporter
// ------------------------------------------
module nbe_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cor_err_i,
    input wire logic unc_err_i,
    input wire logic por_i,
    input wire logic nmi_o,
    input wire logic puc_o
);
    logic [2:0] ctl;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    // Shadow of the enables; power-on reset leaves the control word alone, as the block does.
    always_ff @(posedge clk_i)
        if (rst_i)
            ctl <= 3'h0;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == nbe_pkg::ADDR_CONTROL)
            ctl <= wb_dat_i[2:0];
    // Bus timing and the outputs during reset.
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !puc_o && !nmi_o && !wb_ack_o)
        else $error("output active after reset");
    // Error reporting; the delay range covers two synchroniser stages plus detection.
    puc_len_a: assert property ($rose(puc_o) |-> puc_o [*4] ##1 !puc_o)
        else $error("reset request length wrong");
    unc_reset_a: assert property ($rose(unc_err_i) && ctl[0] |-> ##[2:10] puc_o)
        else $error("no reset for uncorrectable error");
    puc_gate_a: assert property ($rose(puc_o) |-> ctl[0])
        else $error("reset request while reset enable is off");
    cor_nmi_a: assert property ($rose(cor_err_i) && ctl[2] |-> ##[2:10] nmi_o)
        else $error("no nmi for correctable error");
    unc_nmi_a: assert property ($rose(unc_err_i) && ctl == 3'h3 |-> ##[2:10] nmi_o)
        else $error("no nmi for uncorrectable error");
    unc_nmi_miss_a: assert property ($rose(unc_err_i) && ctl == 3'h2 && !nmi_o |-> ##1 !nmi_o [*8])
        else $error("nmi raised with reset enable off");
    nmi_gate_a: assert property ($rose(nmi_o) |-> ctl[2:1] != 2'h0)
        else $error("nmi without an interrupt enable");
    cover property ($rose(puc_o));
    cover property ($rose(nmi_o));
    cover property (wb_ack_o && !wb_we_i);
endmodule

/* File: testbench/nvm_bit_error_reporting_tb.sv */
`timescale 1ns/100ps
module nvm_bit_error_reporting_tb;
    logic clk_i;
    logic rst_i;
    logic por;
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [3:0] sel;
    logic [1:0] src;
    logic [7:0] mhz;
    logic [2:0] ctl;
    logic we, cyc, stb, ack, fetch, wake, inj_cor, inj_unc, cor_err, unc_err, nmi, power_up_clear_reset;
    int errors, compares, seed, cycles, pucs, exp_pucs, p, i, k;
    nbe_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .cor_err_i(cor_err),
        .unc_err_i(unc_err), .fetch_i(fetch), .clk_src_i(src), .clk_mhz_i(mhz), .lpm_wake_i(wake),
        .por_i(por), .nmi_o(nmi), .puc_o(power_up_clear_reset)
    );
    nbe_nvm_model nvm_u (
        .clk_i(clk_i), .rst_i(rst_i), .inj_cor_i(inj_cor), .inj_unc_i(inj_unc), .puc_i(power_up_clear_reset),
        .cor_err_o(cor_err), .unc_err_o(unc_err), .puc_count_o(pucs)
    );
    // ------------------------------------------
    // Clock, hang guard and verdict
    // ------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // The ceiling is about sixteen times the length of the sequence below.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            complete_run;
        end
    end
    task complete_run;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            errors++;
    endtask
    // ------------------------------------------
    // Bus master and stimulus
    // ------------------------------------------
    // The request holds until ack is sampled high; the next call leaves one idle cycle.
    // Only the bench's cycle ceiling ends a wait for ack.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        chk(ack, 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(q, e);
    endtask
    task automatic inject(input int u);
        @(posedge clk_i);
        inj_cor <= (u == 0);
        inj_unc <= (u == 1);
        fetch <= 1'($random(seed));
        @(posedge clk_i);
        inj_cor <= 1'b0;
        inj_unc <= 1'b0;
        repeat (24) @(posedge clk_i);
    endtask
    function automatic logic [31:0] exp_nmi(input int u, input logic [2:0] c);
        if (u == 1)
            return (c[0] && c[1]) ? nbe_pkg::NMI_CODE_UNC : nbe_pkg::VEC_NONE;
        return c[2] ? nbe_pkg::NMI_CODE_COR : nbe_pkg::VEC_NONE;
    endfunction
    initial
    begin
        seed = 43;
        rst_i = 1'b1;
        por = 1'b1;
        {adr, wdat, we, cyc, stb, fetch, wake, inj_cor, inj_unc} = '0;
        sel = 4'hF;
        src = nbe_pkg::SRC_TUNABLE;
        mhz = 8'h08;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        por <= 1'b0;
        // Reset values; the unmapped place swallows its write.
        wb(8'h14, 1'b1, 32'hFFFFFFFF);
        for (i = 0; i < 6; i++)
            rd_chk(8'(i * 4), 32'h0);
        wb(nbe_pkg::ADDR_CONTROL, 1'b1, $random(seed));
        rd_chk(nbe_pkg::ADDR_CONTROL, {29'h0, wdat[2:0]});
        // Random errors and enables against the flag and vector model.
        for (i = 0; i < 16; i++)
        begin
            ctl = 3'($random(seed));
            k = $random(seed) & 1;
            wb(nbe_pkg::ADDR_CONTROL, 1'b1, {29'h0, ctl});
            exp_pucs += k & ctl[0];
            inject(k);
            chk(nmi, exp_nmi(k, ctl) != 0);
            rd_chk(nbe_pkg::ADDR_FLAGS, k ? 32'h2 : 32'h1);
            rd_chk(nbe_pkg::ADDR_RESET_VEC, (k & ctl[0]) ? nbe_pkg::RST_CODE_UNC : 8'h0);
            rd_chk(nbe_pkg::ADDR_NMI_VEC, exp_nmi(k, ctl));
            wb(nbe_pkg::ADDR_FLAGS, 1'b1, 32'h0);
            rd_chk(nbe_pkg::ADDR_FLAGS, k ? 32'h2 : 32'h1);
            wb(nbe_pkg::ADDR_FLAGS, 1'b1, 32'h3);
            rd_chk(nbe_pkg::ADDR_FLAGS, 32'h0);
        end
        // Flags survive the ordinary reset and fall only to power-on reset.
        wb(nbe_pkg::ADDR_CONTROL, 1'b1, 32'h1);
        inject(1);
        exp_pucs++;
        inject(0);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(nbe_pkg::ADDR_FLAGS, 32'h3);
        por <= 1'b1;
        @(posedge clk_i);
        por <= 1'b0;
        rd_chk(nbe_pkg::ADDR_FLAGS, 32'h0);
        chk(pucs, exp_pucs);
        // Fast clocks while fetching: any reset they cause must carry no code.
        wb(nbe_pkg::ADDR_CONTROL, 1'b1, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            src <= 2'(i);
            mhz <= i ? 8'h14 : nbe_pkg::TUNABLE_OSC_BAD_MHZ;
            fetch <= 1'b1;
            repeat (300) @(posedge clk_i);
            fetch <= 1'b0;
            mhz <= 8'h08;
            repeat (24) @(posedge clk_i);
            rd_chk(nbe_pkg::ADDR_RESET_VEC, 32'h0);
            rd_chk(nbe_pkg::ADDR_FLAGS, 32'h0);
        end
        // Wake-up with every enable off gives neither reset nor nmi.
        p = pucs;
        wb(nbe_pkg::ADDR_CONTROL, 1'b1, 32'h0);
        wake <= 1'b1;
        repeat (24) @(posedge clk_i);
        chk(nmi, 1'b0);
        chk(pucs, p);
        rd_chk(nbe_pkg::ADDR_STATUS, 32'h1);
        wb(nbe_pkg::ADDR_FLAGS, 1'b1, 32'h3);
        rd_chk(nbe_pkg::ADDR_FLAGS, 32'h0);
        wake <= 1'b0;
        complete_run;
    end
endmodule
bind nbe_top nbe_properties chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .cor_err_i(cor_err_i), .unc_err_i(unc_err_i), .por_i(por_i), .nmi_o(nmi_o), .puc_o(puc_o)
);
